// file: design/pif_flag_bank.sv
`timescale 1ns/1ps
module pif_flag_bank
    import pif_pkg::*;
(
    input  wire logic                      sys_clk,
    input  wire logic                      reset_n,
    input  wire logic [pif_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [pif_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    input  wire pif_pkg::pif_evt_t         evt,
    input  wire logic                      ext_int_pin,
    input  wire logic [4:0]                pin_change_flags,
    input  wire logic [3:0]                serial_flags,
    output logic                           irq_request
);
    import pif_pkg::*;

    pif_state_t      st_reg;
    pif_state_t      st_next;
    logic [8:0][7:0] hw_set;
    logic [8:0][7:0] view;
    logic [8:0]      bank_hit;
    logic            ext_edge;
    logic            gate_fell;
    logic            t4_set;
    logic            t2_set;
    logic            ccp1_set;
    logic            ccp2_set;
    logic [5:0]      wr_idx;
    logic [5:0]      rd_idx;
    logic            wr_fire;
    logic            wr_ok;
    logic            rd_ok;

    // ********************************
    // event decode
    // ********************************
    // external edge polarity: 1 rising, 0 falling
    assign ext_edge = st_reg.ctrl[BIT_EDGE]
                    ? (st_reg.ext_sync2 & ~st_reg.ext_prev)
                    : (~st_reg.ext_sync2 & st_reg.ext_prev);
    assign gate_fell = st_reg.gate_prev & ~evt.tmr1_gate;
    assign t4_set = evt.tmr4_post_ovf
                  | (evt.tmr4_match & evt.tmr4_ratio_one);
    assign t2_set = evt.tmr2_post_ovf
                  | (evt.tmr2_match & evt.tmr2_ratio_one);

    function automatic logic ccp_hit(input pif_ccp_t c);
        logic hit;
        hit = 1'b0;
        case (c.mode)
            PIF_CAPTURE: hit = c.capture;
            PIF_COMPARE: hit = c.match;
            PIF_PWM:     hit = c.trail;
            default:     hit = 1'b0;
        endcase
        return hit;
    endfunction

    assign ccp1_set = ccp_hit(evt.ccp1);
    assign ccp2_set = ccp_hit(evt.ccp2);

    assign hw_set[0] = {2'b00, evt.tmr0_ovf, 4'h0, ext_edge};
    assign hw_set[1] = {evt.osc_fail, evt.clk_switch, 4'h0,
                        evt.adc_thresh, evt.adc_done};
    assign hw_set[2] = {1'b0, evt.zcd, 4'h0, evt.cmp2, evt.cmp1};
    assign hw_set[3] = {6'h00, evt.bus_coll, evt.ssp};
    assign hw_set[4] = {4'h0, t4_set, 1'b0, t2_set, evt.tmr1_ovf};
    assign hw_set[5] = {evt.clc_out, 3'b000, gate_fell};
    assign hw_set[6] = {evt.cr_event, 5'h00, ccp2_set, ccp1_set};
    assign hw_set[7] = {2'b00, evt.nvm_done, 4'h0,
                        evt.cwg_shutdown};
    assign hw_set[8] = {evt.lcd_event, evt.rtc_event, 3'b000,
                        evt.smt_pw_acq, evt.smt_pr_acq, evt.smt_ovf};

    // ********************************
    // flag view and request gating
    // ********************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_BANK; gi++) begin : g_bank
            if (gi == R_PIN) begin : g_pin
                assign view[gi] = st_reg.req[gi]
                    | ({7'h00, |pin_change_flags} << BIT_IOC);
            end else if (gi == R_SER) begin : g_ser
                assign view[gi] = st_reg.req[gi]
                    | {serial_flags, 4'h0};
            end else begin : g_plain
                assign view[gi] = st_reg.req[gi];
            end
            assign bank_hit[gi] = |(view[gi] & st_reg.en[gi]);
        end
    endgenerate

    // ********************************
    // bus decode
    // ********************************
    assign wr_idx  = st_reg.aw_addr[ADDR_W-1:2];
    assign rd_idx  = s_axi_araddr[ADDR_W-1:2];
    assign wr_fire = st_reg.aw_got & st_reg.w_got;
    assign wr_ok   = (wr_idx <= IDX_LAST)
                   & (st_reg.aw_addr[1:0] == 2'b00);
    assign rd_ok   = (rd_idx <= IDX_LAST)
                   & (s_axi_araddr[1:0] == 2'b00);

    assign s_axi_awready = ~st_reg.aw_got & ~st_reg.bvalid;
    assign s_axi_wready  = ~st_reg.w_got & ~st_reg.bvalid;
    assign s_axi_bvalid  = st_reg.bvalid;
    assign s_axi_bresp   = st_reg.bresp;
    assign s_axi_arready = ~st_reg.rvalid;
    assign s_axi_rvalid  = st_reg.rvalid;
    assign s_axi_rdata   = st_reg.rdata;
    assign s_axi_rresp   = st_reg.rresp;
    assign irq_request   = st_reg.irq;

    // ********************************
    // next state
    // ********************************
    always_comb begin
        st_next = st_reg;
        // synchroniser: first stage feeds only the second
        st_next.ext_sync1 = ext_int_pin;
        st_next.ext_sync2 = st_reg.ext_sync1;
        st_next.ext_prev  = st_reg.ext_sync2;
        st_next.gate_prev = evt.tmr1_gate;

        if (s_axi_awvalid && s_axi_awready) begin
            st_next.aw_got  = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_next.w_got   = 1'b1;
            st_next.w_byte  = s_axi_wdata[7:0];
            st_next.w_lane0 = s_axi_wstrb[0];
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end

        if (wr_fire) begin
            st_next.aw_got = 1'b0;
            st_next.w_got  = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp  = wr_ok ? RESP_OKAY : RESP_SLV;
            if (wr_ok && st_reg.w_lane0) begin
                // control bits 7, 6 and 0
                if (wr_idx == IDX_CTRL) begin
                    st_next.ctrl = st_reg.w_byte & CTRL_MASK;
                end
                for (int i = 0; i < NUM_BANK; i++) begin
                    if (wr_idx == 6'(IDX_EN0 + i)) begin
                        st_next.en[i] = st_reg.w_byte & EN_MASK[i];
                    end
                    if (wr_idx == 6'(IDX_REQ0 + i)) begin
                        st_next.req[i] =
                            (st_reg.req[i] & ~REQ_MASK[i])
                            | (st_reg.w_byte & REQ_MASK[i]);
                    end
                end
            end
        end

        // no enable term in the set
        // set after the write so a same-cycle event wins
        for (int i = 0; i < NUM_BANK; i++) begin
            st_next.req[i] = st_next.req[i]
                           | (hw_set[i] & REQ_MASK[i]);
        end

        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !st_reg.rvalid) begin
            st_next.rvalid = 1'b1;
            st_next.rresp  = rd_ok ? RESP_OKAY : RESP_SLV;
            st_next.rdata  = RDATA_ZERO;
            // upper bits and gaps read zero
            if (rd_ok && rd_idx == IDX_CTRL) begin
                st_next.rdata[7:0] = st_reg.ctrl;
            end
            for (int i = 0; i < NUM_BANK; i++) begin
                if (rd_ok && rd_idx == 6'(IDX_EN0 + i)) begin
                    st_next.rdata[7:0] = st_reg.en[i];
                end
                if (rd_ok && rd_idx == 6'(IDX_REQ0 + i)) begin
                    st_next.rdata[7:0] = view[i];
                end
            end
        end

        st_next.irq = st_reg.ctrl[BIT_GIE]
            & (bank_hit[0]
               | (st_reg.ctrl[BIT_PERIPHERAL_IRQ_GATE] & |bank_hit[8:1]));
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg         <= '0;
            st_reg.ctrl    <= CTRL_RST;
            st_reg.req     <= {NUM_BANK{FLAG_RST}};
            st_reg.bresp   <= RESP_OKAY;
            st_reg.rresp   <= RESP_OKAY;
            st_reg.rdata   <= RDATA_ZERO;
        end else begin
            st_reg <= st_next;
        end
    end

    // ********************************
    // checks
    // ********************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_t4_set: assert property (
        evt.tmr4_match && evt.tmr4_ratio_one
        |=> st_reg.req[R_TIM][B_T4])
        else $error("timer4 flag missed 1:1 match");
    a_t4_ovf: assert property (
        evt.tmr4_post_ovf |=> st_reg.req[R_TIM][B_T4])
        else $error("timer4 flag missed overflow");
    a_t2_set: assert property (
        evt.tmr2_post_ovf |=> st_reg.req[R_TIM][B_T2])
        else $error("timer2 flag missed overflow");
    a_t1_set: assert property (
        evt.tmr1_ovf |=> st_reg.req[R_TIM][B_T1])
        else $error("timer1 flag missed overflow");
    a_cell_set: assert property (
        evt.clc_out[0] |=> st_reg.req[R_CLC][B_CLC1])
        else $error("logic cell1 flag not set");
    a_gate_fall: assert property (
        $fell(evt.tmr1_gate) |=> st_reg.req[R_CLC][B_GATE])
        else $error("gate flag not set on fall");
    a_cr_set: assert property (
        evt.cr_event |=> st_reg.req[R_REC][B_CR])
        else $error("recovery flag not set");
    a_ccp_pwm: assert property (
        evt.ccp1.mode == PIF_PWM && evt.ccp1.trail
        |=> st_reg.req[R_REC][B_CCP1])
        else $error("capture unit1 flag missed edge");
    a_nvm_set: assert property (
        evt.nvm_done |=> st_reg.req[R_MEM][B_NVM])
        else $error("memory flag not set");
    a_cwg_set: assert property (
        evt.cwg_shutdown |=> st_reg.req[R_MEM][B_CWG])
        else $error("waveform flag not set");
    a_lcd_set: assert property (
        evt.lcd_event |=> st_reg.req[R_DSP][B_LCD])
        else $error("display flag not set");
    a_rtc_set: assert property (
        evt.rtc_event |=> st_reg.req[R_DSP][B_RTC])
        else $error("calendar flag not set");
    a_pwa_set: assert property (
        evt.smt_pw_acq |=> st_reg.req[R_DSP][B_PWA])
        else $error("width acquisition flag not set");
    a_pra_set: assert property (
        evt.smt_pr_acq |=> st_reg.req[R_DSP][B_PRA])
        else $error("period acquisition flag not set");
    a_smt_set: assert property (
        evt.smt_ovf |=> st_reg.req[R_DSP][B_SMT])
        else $error("measure overflow flag not set");
    a_set_noen: assert property (
        evt.cr_event && !st_reg.en[R_REC][B_CR]
        && st_reg.ctrl == CTRL_RST |=> st_reg.req[R_REC][B_CR])
        else $error("flag lost with enables off");
    a_flag_hold: assert property (
        !wr_fire && hw_set[R_TIM] == FLAG_RST
        |=> $stable(st_reg.req[R_TIM]))
        else $error("timer flags changed unprompted");
    a_gap_zero: assert property (
        st_reg.rvalid |-> st_reg.rdata[31:8] == 24'h00_0000
        && (st_reg.req[R_TIM] & ~REQ_MASK[R_TIM]) == FLAG_RST)
        else $error("unimplemented bits not zero");
    a_bad_write: assert property (
        wr_fire && !wr_ok |=> $stable(st_reg.ctrl)
        && $stable(st_reg.en))
        else $error("refused write changed a register");
    a_en_write: assert property (
        wr_fire && wr_ok && st_reg.w_lane0
        && wr_idx == 6'(IDX_EN0 + R_TIM)
        |=> st_reg.en[R_TIM]
            == ($past(st_reg.w_byte) & EN_MASK[R_TIM]))
        else $error("enable write not stored");
    a_peripheral_irq_gate_gate: assert property (
        !st_reg.ctrl[BIT_PERIPHERAL_IRQ_GATE] && !bank_hit[0]
        |=> !irq_request)
        else $error("request without peripheral gate");
    a_ioc_live: assert property (
        view[R_PIN][BIT_IOC] == (|pin_change_flags)
        && !st_reg.req[R_PIN][BIT_IOC])
        else $error("pin change summary wrong");
    a_irq_raise: assert property (
        st_reg.ctrl[BIT_GIE] && st_reg.ctrl[BIT_PERIPHERAL_IRQ_GATE]
        && bank_hit[R_TIM] |=> irq_request)
        else $error("request not raised");

endmodule

// file: design/pif_pkg.sv
package pif_pkg;

    // ********************************
    // bus and map
    // ********************************
    localparam int          ADDR_W     = 8;
    localparam int          NUM_BANK   = 9;
    localparam logic [5:0]  IDX_CTRL   = 6'h00;
    localparam logic [5:0]  IDX_EN0    = 6'h01;
    localparam logic [5:0]  IDX_REQ0   = 6'h0A;
    localparam logic [5:0]  IDX_LAST   = 6'h12;
    localparam logic [1:0]  RESP_OKAY  = 2'b00;
    localparam logic [1:0]  RESP_SLV   = 2'b10;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    // ********************************
    // field layout
    // ********************************
    localparam int BIT_GIE   = 7;
    localparam int BIT_PERIPHERAL_IRQ_GATE  = 6;
    localparam int BIT_EDGE  = 0;
    localparam int BIT_IOC   = 4;
    localparam int R_PIN     = 0;
    localparam int R_SER     = 3;
    localparam int R_TIM     = 4;
    localparam int R_CLC     = 5;
    localparam int R_REC     = 6;
    localparam int R_MEM     = 7;
    localparam int R_DSP     = 8;
    localparam int B_T4      = 3;
    localparam int B_T2      = 1;
    localparam int B_T1      = 0;
    localparam int B_CLC1    = 4;
    localparam int B_GATE    = 0;
    localparam int B_CR      = 7;
    localparam int B_CCP1    = 0;
    localparam int B_NVM     = 5;
    localparam int B_CWG     = 0;
    localparam int B_LCD     = 7;
    localparam int B_RTC     = 6;
    localparam int B_PWA     = 2;
    localparam int B_PRA     = 1;
    localparam int B_SMT     = 0;

    localparam logic [7:0] CTRL_MASK = 8'hC1;
    localparam logic [7:0] CTRL_RST  = 8'h00;
    localparam logic [7:0] FLAG_RST  = 8'h00;
    // index 8 first, index 0 last
    localparam logic [8:0][7:0] EN_MASK = {
        8'hC7, 8'h21, 8'h83, 8'hF1, 8'h0B,
        8'hF3, 8'h43, 8'hC3, 8'h31};
    // read-only live bits excluded from the stored flags
    localparam logic [8:0][7:0] REQ_MASK = {
        8'hC7, 8'h21, 8'h83, 8'hF1, 8'h0B,
        8'h03, 8'h43, 8'hC3, 8'h21};

    typedef enum logic [1:0] {
        PIF_CAPTURE = 2'b00,
        PIF_COMPARE = 2'b01,
        PIF_PWM     = 2'b11
    } pif_ccp_mode_t;

    typedef struct packed {
        pif_ccp_mode_t mode;
        logic          capture;
        logic          match;
        logic          trail;
    } pif_ccp_t;

    typedef struct packed {
        logic       tmr0_ovf;
        logic       osc_fail;
        logic       clk_switch;
        logic       adc_thresh;
        logic       adc_done;
        logic       zcd;
        logic       cmp2;
        logic       cmp1;
        logic       bus_coll;
        logic       ssp;
        logic       tmr4_post_ovf;
        logic       tmr4_match;
        logic       tmr4_ratio_one;
        logic       tmr2_post_ovf;
        logic       tmr2_match;
        logic       tmr2_ratio_one;
        logic       tmr1_ovf;
        logic [3:0] clc_out;
        logic       tmr1_gate;
        logic       cr_event;
        pif_ccp_t   ccp2;
        pif_ccp_t   ccp1;
        logic       nvm_done;
        logic       cwg_shutdown;
        logic       lcd_event;
        logic       rtc_event;
        logic       smt_pw_acq;
        logic       smt_pr_acq;
        logic       smt_ovf;
    } pif_evt_t;

    typedef struct packed {
        logic [7:0]        ctrl;
        logic [8:0][7:0]   en;
        logic [8:0][7:0]   req;
        logic              ext_sync1;
        logic              ext_sync2;
        logic              ext_prev;
        logic              gate_prev;
        logic              aw_got;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_got;
        logic [7:0]        w_byte;
        logic              w_lane0;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic              irq;
    } pif_state_t;

endpackage

// file: tb/pif_evt_model.sv
`timescale 1ns/1ps
module pif_evt_model
    import pif_pkg::*;
(
    input  wire logic         sys_clk,
    input  wire logic         reset_n,
    input  wire logic         fire,
    input  wire logic [4:0]   code,
    output pif_pkg::pif_evt_t evt
);
    pif_evt_t e;

    // ********************************
    // event decode
    // ********************************
    always_comb begin
        e = '0;
        case (code)
            5'd0: e.tmr4_post_ovf = 1'b1;
            5'd1: {e.tmr4_match, e.tmr4_ratio_one} = 2'b11;
            5'd2: e.tmr4_match = 1'b1;
            5'd3: e.tmr2_post_ovf = 1'b1;
            5'd4: {e.tmr2_match, e.tmr2_ratio_one} = 2'b11;
            5'd5: e.tmr2_match = 1'b1;
            5'd6: e.tmr1_ovf = 1'b1;
            5'd7, 5'd8, 5'd9, 5'd10: e.clc_out = 4'(1 << (code - 5'd7));
            5'd11: e.tmr1_gate = 1'b1;
            5'd12: e.cr_event = 1'b1;
            5'd13: e.ccp1 = '{PIF_CAPTURE, 1'b1, 1'b0, 1'b0};
            5'd14: e.ccp1 = '{PIF_COMPARE, 1'b0, 1'b1, 1'b0};
            5'd15: e.ccp1 = '{PIF_PWM, 1'b0, 1'b0, 1'b1};
            5'd16: e.ccp1 = '{PIF_CAPTURE, 1'b0, 1'b1, 1'b0};
            5'd17: e.ccp2 = '{PIF_COMPARE, 1'b0, 1'b1, 1'b0};
            5'd18: e.ccp2 = '{pif_ccp_mode_t'(2'b10), 1'b1, 1'b0, 1'b0};
            5'd19: e.nvm_done = 1'b1;
            5'd20: e.cwg_shutdown = 1'b1;
            5'd21: e.lcd_event = 1'b1;
            5'd22: e.rtc_event = 1'b1;
            5'd23: e.smt_pw_acq = 1'b1;
            5'd24: e.smt_pr_acq = 1'b1;
            5'd25: e.smt_ovf = 1'b1;
            default: e = '0;
        endcase
    end

    // one-cycle strobes; the gate level drops again right after
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            evt <= '0;
        end else begin
            evt <= fire ? e : '0;
        end
    end
endmodule

// file: tb/pif_flag_bank_tb.sv
`timescale 1ns/1ps
module pif_flag_bank_tb;
    import pif_pkg::*;
    logic              sys_clk, reset_n, fire, irq_request;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic              awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready, ext_int_pin;
    logic [31:0]       wdata, rdata, rd_data;
    logic [3:0]        wstrb, serial_flags;
    logic [1:0]        bresp, rresp, rd_resp, wr_resp;
    logic [4:0]        code, pin_change_flags;
    pif_evt_t          evt;
    int                bad_count = 0;
    int                n_tests = 0;
    int                cycles = 0;
    int                i;
    localparam int EV_IDX [26] = '{4, 4, 4, 4, 4, 4, 4, 5, 5, 5, 5, 5, 6,
        6, 6, 6, 6, 6, 6, 7, 7, 8, 8, 8, 8, 8};
    localparam logic [7:0] EV_VAL [26] = '{8'h08, 8'h08, 8'h00, 8'h02,
        8'h02, 8'h00, 8'h01, 8'h10, 8'h20, 8'h40, 8'h80, 8'h01, 8'h80,
        8'h01, 8'h01, 8'h01, 8'h00, 8'h02, 8'h00, 8'h20, 8'h01, 8'h80,
        8'h40, 8'h04, 8'h02, 8'h01};

    pif_flag_bank dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .evt(evt), .ext_int_pin(ext_int_pin),
        .pin_change_flags(pin_change_flags), .serial_flags(serial_flags),
        .irq_request(irq_request));
    pif_evt_model u_evt (.sys_clk(sys_clk), .reset_n(reset_n),
        .fire(fire), .code(code), .evt(evt));

    // ********************************
    // clock and watchdog
    // ********************************
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            $display("BAD %0t timeout", $time);
            bad_count++;
            complete_run();
        end
    end

    // ********************************
    // bus tasks
    // ********************************
    function automatic logic [ADDR_W-1:0] ba(input int idx);
        return ADDR_W'(idx * 4);
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic aw_p, w_p;
        aw_p = 1'b1;
        w_p = 1'b1;
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h00_0000, d};
        wstrb <= 4'h1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw_p || w_p) begin
            @(posedge sys_clk);
            if (aw_p && awready === 1'b1) begin
                aw_p = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_p && wready === 1'b1) begin
                w_p = 1'b0;
                wvalid <= 1'b0;
            end
        end
        do @(posedge sys_clk); while (bvalid !== 1'b1);
        wr_resp = bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge sys_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge sys_clk); while (rvalid !== 1'b1);
        rd_data = rdata;
        rd_resp = rresp;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        chk(rd_data, {24'h00_0000, e});
        chk(32'(rd_resp), 32'(RESP_OKAY));
    endtask
    task automatic pulse(input int c);
        fire <= 1'b1;
        code <= 5'(c);
        @(posedge sys_clk);
        fire <= 1'b0;
        cyc(4);
    endtask
    task automatic ev_case(input int c);
        pulse(c);
        rd_chk(ba(IDX_REQ0 + EV_IDX[c]), EV_VAL[c]);
        chk(32'(irq_request), 32'h0000_0000);
        wr(ba(IDX_REQ0 + EV_IDX[c]), 8'h00);
        rd_chk(ba(IDX_REQ0 + EV_IDX[c]), 8'h00);
    endtask
    task automatic irq_is(input logic e);
        cyc(3);
        chk(32'(irq_request), 32'(e));
    endtask
    task complete_run;
        $display("bad_count=%0d n_tests=%0d", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ********************************
    // test sequence
    // ********************************
    initial begin
        {reset_n, fire, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb, code} = '0;
        {ext_int_pin, pin_change_flags, serial_flags} = '0;
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        for (i = 0; i <= IDX_LAST; i++) begin
            rd_chk(ba(i), 8'h00);
        end
        rd(8'h4C);
        chk(32'(rd_resp), 32'(RESP_SLV));
        wr(8'h4C, 8'hFF);
        chk(32'(wr_resp), 32'(RESP_SLV));
        for (i = 0; i < 10; i++) begin
            wr(ba(i), 8'hFF);
            chk(32'(wr_resp), 32'(RESP_OKAY));
            rd_chk(ba(i), i == 0 ? CTRL_MASK : EN_MASK[i - 1]);
            wr(ba(i), 8'h00);
        end
        for (i = 0; i < 9; i++) begin
            wr(ba(IDX_REQ0 + i), 8'hFF);
            rd_chk(ba(IDX_REQ0 + i), REQ_MASK[i]);
            wr(ba(IDX_REQ0 + i), 8'h00);
        end
        for (i = 0; i < 19; i++) begin
            ev_case(i);
        end
        for (i = 19; i < 26; i++) begin
            ev_case(i);
        end
        pulse(6);
        wr(ba(IDX_REQ0 + 4), 8'h00);
        wr(ba(IDX_EN0 + 4), 8'h01);
        wr(ba(0), 8'hC0);
        irq_is(1'b0);
        pulse(6);
        irq_is(1'b1);
        wr(ba(0), 8'h80);
        irq_is(1'b0);
        wr(ba(0), 8'h40);
        irq_is(1'b0);
        wr(ba(0), 8'hC0);
        irq_is(1'b1);
        wr(ba(IDX_REQ0 + 4), 8'h00);
        irq_is(1'b0);
        wr(ba(IDX_EN0), 8'h01);
        wr(ba(0), 8'h81);
        ext_int_pin <= 1'b1;
        cyc(6);
        rd_chk(ba(IDX_REQ0), 8'h01);
        irq_is(1'b1);
        wr(ba(IDX_REQ0), 8'h00);
        ext_int_pin <= 1'b0;
        cyc(6);
        rd_chk(ba(IDX_REQ0), 8'h00);
        // falling edge mode: rise ignored, fall sets
        wr(ba(0), 8'h80);
        ext_int_pin <= 1'b1;
        cyc(6);
        rd_chk(ba(IDX_REQ0), 8'h00);
        ext_int_pin <= 1'b0;
        cyc(6);
        rd_chk(ba(IDX_REQ0), 8'h01);
        irq_is(1'b1);
        wr(ba(IDX_REQ0), 8'h00);
        pin_change_flags <= 5'h04;
        serial_flags <= 4'hA;
        cyc(3);
        wr(ba(IDX_REQ0), 8'h00);
        rd_chk(ba(IDX_REQ0), 8'h10);
        rd_chk(ba(IDX_REQ0 + 3), 8'hA0);
        pin_change_flags <= 5'h00;
        cyc(3);
        rd_chk(ba(IDX_REQ0), 8'h00);
        // second reset in mid-run must clear everything again
        wr(ba(IDX_REQ0 + 8), 8'hFF);
        reset_n <= 1'b0;
        cyc(3);
        reset_n <= 1'b1;
        cyc(1);
        rd_chk(ba(IDX_REQ0 + 8), 8'h00);
        rd_chk(ba(0), 8'h00);
        complete_run();
    end
endmodule
